// ==== rtl/plc_pkg.sv ====
// plc_pkg: constants and types for the 32-line parallel line controller.
// assumes: one 100 MHz clock, classic wishbone register access with 32-bit data.
package plc_pkg;
	// ----------------------------------------------------------------
	// widths
	// ----------------------------------------------------------------
	localparam int unsigned NUM_LINES = 32;
	localparam int unsigned ADR_W = 8;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_OWNER_ENABLE = 8'h00;
	localparam logic [7:0] OFS_OWNER_DISABLE = 8'h04;
	localparam logic [7:0] OFS_OWNER_STATUS = 8'h08;
	localparam logic [7:0] OFS_OUTPUT_ENABLE = 8'h10;
	localparam logic [7:0] OFS_OUTPUT_DISABLE = 8'h14;
	localparam logic [7:0] OFS_OUTPUT_STATUS = 8'h18;
	localparam logic [7:0] OFS_FILTER_ENABLE = 8'h20;
	localparam logic [7:0] OFS_FILTER_DISABLE = 8'h24;
	localparam logic [7:0] OFS_FILTER_STATUS = 8'h28;
	localparam logic [7:0] OFS_SET_OUTPUT_DATA = 8'h30;
	localparam logic [7:0] OFS_CLEAR_OUTPUT_DATA = 8'h34;
	localparam logic [7:0] OFS_OUTPUT_DATA_STATUS = 8'h38;
	localparam logic [7:0] OFS_PIN_LEVEL_STATUS = 8'h3C;
	localparam logic [7:0] OFS_CHANGE_IRQ_ENABLE = 8'h40;
	localparam logic [7:0] OFS_CHANGE_IRQ_DISABLE = 8'h44;
	localparam logic [7:0] OFS_CHANGE_IRQ_MASK = 8'h48;
	localparam logic [7:0] OFS_CHANGE_IRQ_STATUS = 8'h4C;
	localparam logic [7:0] OFS_CHANGE_IRQ_CLEAR = 8'h50;

	// ----------------------------------------------------------------
	// line masks and reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] DEFINED_LINES = 32'hFFFF_FFFF;
	localparam logic [31:0] DEDICATED_LINES = 32'h018F_0000;
	localparam logic [31:0] OWNER_RESET = 32'h01FF_FFFF;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// ----------------------------------------------------------------
	// per-line configuration carried as one group
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] owner;
		logic [31:0] dir;
		logic [31:0] data;
		logic [31:0] filt;
		logic [31:0] mask;
	} plc_cfg_t;
endpackage : plc_pkg

// ==== rtl/plc_top.sv ====
// plc_top: 32-line parallel line controller with pin/peripheral ownership mux.
// assumes: pins and peripheral inputs are external; peripheral outputs share clk_i.
//
// Implementation choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps

// Notes on behaviour
// - thirty-two lines, six dedicated, others shared
// - lines 0 to 24 controller-owned inputs
// - lines 25 to 31 peripheral-owned after reset
// - enable/disable set ownership; status reads ownership
// - dedicated lines ignore ownership writes, read one
// - peripheral input held zero when controller owns
// - direction set/clear, readable, drives only owned
// - set/clear output data, readable in status
// - owned non-output line left undriven
// - unowned line follows peripheral output and direction
// - pin level status shows actual pin level
// - per-line glitch filter, enable/disable/status
// - interrupt mask set/clear, readable
// - any pin level change sets status bit
// - interrupt high while masked status bit set
// - status read returns bits then clears all but changes seen in the read cycle
// - 32-bit registers, undefined bits ignored, read zero
module plc_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// package pins
	input wire logic [31:0] pin_in_i,
	output logic [31:0] pin_out_o,
	output logic [31:0] pin_oe_o,
	// multiplexed peripheral signals
	input wire logic [31:0] periph_out_i,
	input wire logic [31:0] periph_oe_i,
	output logic [31:0] periph_in_o,
	// interrupt to the interrupt controller
	output logic irq_o
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// byte-lane write mask restricted to defined lines
	function automatic logic [31:0] lane_mask(input logic [3:0] sel);
		lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}} & plc_pkg::DEFINED_LINES;
	endfunction : lane_mask

	// set bits win over clear bits of a set/clear register pair
	function automatic logic [31:0] set_clr(input logic [31:0] cur, input logic [31:0] s, input logic [31:0] c);
		set_clr = (cur & ~c) | s;
	endfunction : set_clr

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	plc_pkg::plc_cfg_t cfg_q;
	logic [31:0] sync1_q;
	logic [31:0] sync2_q;
	logic [31:0] sync3_q;
	logic [31:0] level_q;
	logic [31:0] level_prev_q;
	logic [31:0] irq_stat_q;
	logic ack_q;
	logic [31:0] rdat_q;
	logic irq_q;
	logic [31:0] pin_out_q;
	logic [31:0] pin_oe_q;
	logic [31:0] periph_in_q;
	logic sync1_vld_q;
	logic sync2_vld_q;
	logic level_vld_q;
	logic prev_vld_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic req;
	logic wr;
	logic rd;
	logic [31:0] wmask;
	logic [31:0] wdat;
	logic [31:0] change;
	logic [31:0] level_d;
	logic [31:0] owner_view;

	// a request is taken once, in the cycle before ack rises
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign wr = req & wb_we_i;
	assign rd = req & ~wb_we_i;
	assign wmask = lane_mask(wb_sel_i);
	assign wdat = wb_dat_i & wmask;
	// dedicated lines always report controller ownership
	assign owner_view = cfg_q.owner | plc_pkg::DEDICATED_LINES;

	// write strobes, one word per register
	function automatic logic [31:0] wr_hit(input logic w, input logic [7:0] a, input logic [7:0] ofs,
		input logic [31:0] d);
		wr_hit = (w && a == ofs) ? d : plc_pkg::ZERO_WORD;
	endfunction : wr_hit

	// ----------------------------------------------------------------
	// register write strobes
	// ----------------------------------------------------------------
	logic [31:0] own_set;
	logic [31:0] own_clr;
	logic [31:0] dir_set;
	logic [31:0] dir_clr;
	logic [31:0] data_set;
	logic [31:0] data_clr;
	logic [31:0] filt_set;
	logic [31:0] filt_clr;
	logic [31:0] mask_set;
	logic [31:0] mask_clr;
	logic [31:0] stat_clr;

	// ownership pair; dedicated lines are never released
	assign own_set = wr_hit(wr, wb_adr_i, plc_pkg::OFS_OWNER_ENABLE, wdat);
	assign own_clr = wr_hit(wr, wb_adr_i, plc_pkg::OFS_OWNER_DISABLE, wdat) & ~plc_pkg::DEDICATED_LINES;

	// direction pair
	assign dir_set = wr_hit(wr, wb_adr_i, plc_pkg::OFS_OUTPUT_ENABLE, wdat);
	assign dir_clr = wr_hit(wr, wb_adr_i, plc_pkg::OFS_OUTPUT_DISABLE, wdat);

	// output data pair
	assign data_set = wr_hit(wr, wb_adr_i, plc_pkg::OFS_SET_OUTPUT_DATA, wdat);
	assign data_clr = wr_hit(wr, wb_adr_i, plc_pkg::OFS_CLEAR_OUTPUT_DATA, wdat);

	// glitch filter pair
	assign filt_set = wr_hit(wr, wb_adr_i, plc_pkg::OFS_FILTER_ENABLE, wdat);
	assign filt_clr = wr_hit(wr, wb_adr_i, plc_pkg::OFS_FILTER_DISABLE, wdat);

	// interrupt mask pair
	assign mask_set = wr_hit(wr, wb_adr_i, plc_pkg::OFS_CHANGE_IRQ_ENABLE, wdat);
	assign mask_clr = wr_hit(wr, wb_adr_i, plc_pkg::OFS_CHANGE_IRQ_DISABLE, wdat);

	// write-one-to-clear of pending change bits
	assign stat_clr = wr_hit(wr, wb_adr_i, plc_pkg::OFS_CHANGE_IRQ_CLEAR, wdat);

	// ----------------------------------------------------------------
	// wishbone handshake
	// ----------------------------------------------------------------
	// ack for one cycle per request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	// read data mux, registered with ack; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= plc_pkg::ZERO_WORD;
		end else if (rd) begin
			case (wb_adr_i)
				plc_pkg::OFS_OWNER_STATUS: rdat_q <= owner_view;
				plc_pkg::OFS_OUTPUT_STATUS: rdat_q <= cfg_q.dir;
				plc_pkg::OFS_FILTER_STATUS: rdat_q <= cfg_q.filt;
				plc_pkg::OFS_OUTPUT_DATA_STATUS: rdat_q <= cfg_q.data;
				plc_pkg::OFS_PIN_LEVEL_STATUS: rdat_q <= level_q;
				plc_pkg::OFS_CHANGE_IRQ_MASK: rdat_q <= cfg_q.mask;
				plc_pkg::OFS_CHANGE_IRQ_STATUS: rdat_q <= irq_stat_q;
				default: rdat_q <= plc_pkg::ZERO_WORD;
			endcase
		end else begin
			rdat_q <= plc_pkg::ZERO_WORD;
		end
	end

	// ----------------------------------------------------------------
	// configuration registers
	// ----------------------------------------------------------------
	// ownership: dedicated bits never stored as peripheral-owned
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q.owner <= plc_pkg::OWNER_RESET;
		end else begin
			cfg_q.owner <= set_clr(cfg_q.owner, own_set, own_clr);
		end
	end

	// direction store, kept even while the peripheral owns the line
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q.dir <= plc_pkg::ZERO_WORD;
		end else begin
			cfg_q.dir <= set_clr(cfg_q.dir, dir_set, dir_clr);
		end
	end

	// output data store
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q.data <= plc_pkg::ZERO_WORD;
		end else begin
			cfg_q.data <= set_clr(cfg_q.data, data_set, data_clr);
		end
	end

	// glitch filter selection
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q.filt <= plc_pkg::ZERO_WORD;
		end else begin
			cfg_q.filt <= set_clr(cfg_q.filt, filt_set, filt_clr);
		end
	end

	// interrupt mask
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_q.mask <= plc_pkg::ZERO_WORD;
		end else begin
			cfg_q.mask <= set_clr(cfg_q.mask, mask_set, mask_clr);
		end
	end

	// ----------------------------------------------------------------
	// pin input path
	// ----------------------------------------------------------------
	// two-flop synchroniser for the asynchronous pin levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_q <= plc_pkg::ZERO_WORD;
			sync2_q <= plc_pkg::ZERO_WORD;
		end else begin
			sync1_q <= pin_in_i;
			sync2_q <= sync1_q;
		end
	end

	// previous synced sample, for the filter compare
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync3_q <= plc_pkg::ZERO_WORD;
		end else begin
			sync3_q <= sync2_q;
		end
	end

	// pipeline fill: marks stages that hold real pin samples
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_vld_q <= 1'b0;
			sync2_vld_q <= 1'b0;
			level_vld_q <= 1'b0;
			prev_vld_q <= 1'b0;
		end else begin
			sync1_vld_q <= 1'b1;
			sync2_vld_q <= sync1_vld_q;
			level_vld_q <= sync2_vld_q;
			prev_vld_q <= level_vld_q;
		end
	end

	// filtered lines take a new level only after two equal samples
	always_comb begin
		level_d = level_q;
		for (int i = 0; i < plc_pkg::NUM_LINES; i++) begin
			if (!cfg_q.filt[i] || sync2_q[i] == sync3_q[i]) begin
				level_d[i] = sync2_q[i];
			end
		end
	end

	// level seen by status, change detect and peripherals
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level_q <= plc_pkg::ZERO_WORD;
			level_prev_q <= plc_pkg::ZERO_WORD;
		end else begin
			level_q <= level_d;
			level_prev_q <= level_q;
		end
	end

	// ----------------------------------------------------------------
	// change interrupt
	// ----------------------------------------------------------------
	// no change reported until both compared samples came from the pins
	assign change = prev_vld_q ? (level_q ^ level_prev_q) : plc_pkg::ZERO_WORD;

	// sticky status: a change in the clearing cycle survives
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_q <= plc_pkg::ZERO_WORD;
		end else if (rd && wb_adr_i == plc_pkg::OFS_CHANGE_IRQ_STATUS) begin
			irq_stat_q <= change;
		end else begin
			irq_stat_q <= (irq_stat_q & ~stat_clr) | change;
		end
	end

	// level interrupt output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_stat_q & cfg_q.mask);
		end
	end

	// ----------------------------------------------------------------
	// pin and peripheral output mux
	// ----------------------------------------------------------------
	// owned lines drive controller data, others the peripheral value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_out_q <= plc_pkg::ZERO_WORD;
		end else begin
			pin_out_q <= (owner_view & cfg_q.data) | (~owner_view & periph_out_i);
		end
	end

	// owned lines use controller direction, others the peripheral enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_oe_q <= plc_pkg::ZERO_WORD;
		end else begin
			pin_oe_q <= (owner_view & cfg_q.dir) | (~owner_view & periph_oe_i);
		end
	end

	// peripheral inputs held at zero on owned and dedicated lines
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			periph_in_q <= plc_pkg::ZERO_WORD;
		end else begin
			periph_in_q <= level_d & ~owner_view & ~plc_pkg::DEDICATED_LINES;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign irq_o = irq_q;
	assign pin_out_o = pin_out_q;
	assign pin_oe_o = pin_oe_q;
	assign periph_in_o = periph_in_q;

endmodule : plc_top

// ==== test/plc_monitor.sv ====
// plc_monitor: port assertions for the parallel line controller.
// assumes: bound to plc_top, one clock, synchronous active-high reset.
`timescale 1ns/1ps
module plc_monitor (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// bus
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// pins, peripherals, interrupt
	input wire logic [31:0] pin_oe_o,
	input wire logic [31:0] periph_oe_i,
	input wire logic [31:0] periph_in_o,
	input wire logic irq_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// a taken request, and a quiet interrupt stretch
	sequence req_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
	sequence idle_hi_s; (irq_o && !wb_cyc_i) [*4]; endsequence
	ack_answer_a: assert property (req_s |=> wb_ack_o) else $error("no ack after request");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_stb_i)) else $error("ack without strobe");
	read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data outside ack");
	dedicated_in_a: assert property ((periph_in_o & plc_pkg::DEDICATED_LINES) == 32'h0000_0000)
		else $error("dedicated line feeds peripheral");
	reset_quiet_a: assert property (disable iff (1'b0) rst_i |=> !irq_o && pin_oe_o == 32'h0000_0000)
		else $error("outputs active after reset");
	irq_hold_a: assert property (idle_hi_s |=> irq_o) else $error("interrupt dropped without access");
	oe_cause_a: assert property ($changed(pin_oe_o) |-> wb_ack_o || $past(wb_ack_o) || $past(rst_i)
		|| $past(rst_i, 2) || periph_oe_i != $past(periph_oe_i) || $past(periph_oe_i) != $past(periph_oe_i, 2))
		else $error("drive enable changed without cause");
endmodule : plc_monitor

bind plc_top plc_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_oe_o(pin_oe_o), .periph_oe_i(periph_oe_i),
	.periph_in_o(periph_in_o), .irq_o(irq_o));

// ==== test/plc_pins_model.sv ====
// plc_pins_model: external circuit and peripheral outputs around the pins.
// assumes: the bench sets the external circuit levels on ext_i.
`timescale 1ns/1ps
module plc_pins_model (
	// design drive and external circuit levels
	input wire logic [31:0] dev_out_i,
	input wire logic [31:0] dev_oe_i,
	input wire logic [31:0] ext_i,
	// wire level and peripheral outputs
	output logic [31:0] pin_o,
	output logic [31:0] per_out_o,
	output logic [31:0] per_oe_o
);
	// upper lines are peripheral outputs idling high
	assign per_oe_o = 32'hFE00_0000;
	assign per_out_o = {7'h7F, ext_i[24:0]};
	// an enabled driver wins, else the external circuit
	assign pin_o = (dev_out_i & dev_oe_i) | (ext_i & ~dev_oe_i);
endmodule : plc_pins_model

// ==== test/tb_top.sv ====
// tb_top: self-checking bench for the parallel line controller.
// assumes: plc_top, plc_pins_model and the bound monitor.
`timescale 1ns/1ps
module tb_top;
	typedef struct {string n; logic [31:0] v;} plc_exp_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hF;
	logic [31:0] wd = 32'h0000_0000, ext = 32'h0000_0000, rdat, pout, poe, pin, pout_p, poe_p, pin_p, r, s, dir;
	int errors = 0, checks = 0, n;
	plc_exp_t q[$];
	always #5 clk_i = ~clk_i;
	plc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rdat), .wb_ack_o(ack), .pin_in_i(pin), .pin_out_o(pout),
		.pin_oe_o(poe), .periph_out_i(pout_p), .periph_oe_i(poe_p), .periph_in_o(pin_p), .irq_o(irq));
	plc_pins_model u_pm (.dev_out_i(pout), .dev_oe_i(poe), .ext_i(ext), .pin_o(pin), .per_out_o(pout_p),
		.per_oe_o(poe_p));
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic results;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : results
	// one classic cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		{cyc, stb, we, adr, wd} <= {2'b11, w, a, d};
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'b1 && k < 20);
		if (k >= 20) begin
			errors++;
			results();
		end
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask : wb
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		q.push_back('{nm, e});
		wb(1'b0, a, 32'h0000_0000);
	endtask : rd
	// compares each read answer with the oldest note
	always @(posedge clk_i) begin
		if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
			chk(q[0].n, q[0].v, rdat);
			q.pop_front();
		end
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		results();
	end
	// main sequence
	initial begin
		void'($urandom(32'hA65A));
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd("owner", plc_pkg::OFS_OWNER_STATUS, plc_pkg::OWNER_RESET);
		rd("dir", plc_pkg::OFS_OUTPUT_STATUS, 32'h0000_0000);
		rd("filt", plc_pkg::OFS_FILTER_STATUS, 32'h0000_0000);
		rd("hole", 8'h0C, 32'h0000_0000);
		chk("oe", 32'hFE00_0000, poe);
		chk("out", 32'hFE00_0000, pout & 32'hFE00_0000);
		$display("test reset done");
		wb(1'b1, plc_pkg::OFS_OWNER_DISABLE, 32'hFFFF_FFFF);
		rd("owner", plc_pkg::OFS_OWNER_STATUS, 32'h018F_0000);
		wb(1'b1, plc_pkg::OFS_OWNER_ENABLE, 32'h0000_00F0);
		rd("owner", plc_pkg::OFS_OWNER_STATUS, plc_pkg::DEDICATED_LINES | 32'h0000_00F0);
		ext <= 32'h0000_00FF;
		repeat (6) @(posedge clk_i);
		chk("periph_in", 32'h0000_000F, pin_p & 32'h0000_00FF);
		$display("test owner done");
		r = $urandom;
		s = $urandom;
		ext <= $urandom;
		dir = r & 32'hFFFF_FFF0;
		wb(1'b1, plc_pkg::OFS_OWNER_ENABLE, 32'hFFFF_FFFF);
		wb(1'b1, plc_pkg::OFS_OUTPUT_ENABLE, r);
		wb(1'b1, plc_pkg::OFS_OUTPUT_DISABLE, 32'h0000_000F);
		wb(1'b1, plc_pkg::OFS_SET_OUTPUT_DATA, s);
		wb(1'b1, plc_pkg::OFS_CLEAR_OUTPUT_DATA, 32'h0000_FFFF);
		rd("dir", plc_pkg::OFS_OUTPUT_STATUS, dir);
		rd("data", plc_pkg::OFS_OUTPUT_DATA_STATUS, s & 32'hFFFF_0000);
		repeat (6) @(posedge clk_i);
		chk("oe", dir, poe);
		chk("out", s & dir & 32'hFFFF_0000, pout & dir);
		rd("level", plc_pkg::OFS_PIN_LEVEL_STATUS, (s & dir & 32'hFFFF_0000) | (ext & ~dir));
		wb(1'b1, plc_pkg::OFS_OWNER_DISABLE, 32'hFE00_0000);
		repeat (2) @(posedge clk_i);
		chk("oe", (dir & 32'h01FF_FFFF) | 32'hFE00_0000, poe);
		$display("test output done");
		sel <= 4'h1;
		wb(1'b1, plc_pkg::OFS_FILTER_ENABLE, 32'h0000_0105);
		sel <= 4'hF;
		wb(1'b1, plc_pkg::OFS_FILTER_DISABLE, 32'h0000_0004);
		rd("filt", plc_pkg::OFS_FILTER_STATUS, 32'h0000_0001);
		repeat (6) @(posedge clk_i);
		wb(1'b0, plc_pkg::OFS_CHANGE_IRQ_STATUS, 32'h0000_0000);
		ext <= ext ^ 32'h0000_0003;
		@(posedge clk_i);
		ext <= ext ^ 32'h0000_0003;
		repeat (8) @(posedge clk_i);
		rd("isr", plc_pkg::OFS_CHANGE_IRQ_STATUS, 32'h0000_0002);
		$display("test filter done");
		wb(1'b1, plc_pkg::OFS_CHANGE_IRQ_ENABLE, 32'h0000_0002);
		rd("mask", plc_pkg::OFS_CHANGE_IRQ_MASK, 32'h0000_0002);
		ext <= ext ^ 32'h0000_0002;
		for (n = 0; n < 10 && irq !== 1'b1; n++) @(posedge clk_i);
		chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
		rd("isr", plc_pkg::OFS_CHANGE_IRQ_STATUS, 32'h0000_0002);
		rd("isr", plc_pkg::OFS_CHANGE_IRQ_STATUS, 32'h0000_0000);
		repeat (3) @(posedge clk_i);
		chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
		wb(1'b1, plc_pkg::OFS_CHANGE_IRQ_DISABLE, 32'h0000_0002);
		ext <= ext ^ 32'h0000_0002;
		repeat (8) @(posedge clk_i);
		chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
		rd("isr", plc_pkg::OFS_CHANGE_IRQ_STATUS, 32'h0000_0002);
		ext <= ext ^ 32'h0000_0006;
		repeat (8) @(posedge clk_i);
		wb(1'b1, plc_pkg::OFS_CHANGE_IRQ_CLEAR, 32'h0000_0002);
		rd("isr", plc_pkg::OFS_CHANGE_IRQ_STATUS, 32'h0000_0004);
		$display("test interrupt done");
		results();
	end
endmodule : tb_top
